// *** core/omcs_ctrl.sv ***
// Control, status and ID link logic of the optical module.
`timescale 1ns/1ps
module omcs_ctrl #(
   parameter int INIT_CYCLES = omcs_pkg::INIT_CYC,
   parameter int ON_MAX_CYCLES = omcs_pkg::ON_MAX_CYC,
   parameter logic [6:0] ID_ADDR = omcs_pkg::ID_ADDR_DEF
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic laserShutoff,
   input wire logic laserFaultSense,
   input wire logic rxPowerSense,
   input wire logic idLinkClock,
   input wire logic idLinkDataIn,
   output logic idLinkDataOut,
   output logic idLinkDataOe,
   output logic laserEnable,
   output logic txFaultOut,
   output logic txFaultOe,
   output logic rxPowerLostOut,
   output logic rxPowerLostOe,
   output logic presenceTieOut,
   output logic presenceTieOe,
   output logic initDone
);
   import omcs_pkg::*;

   logic [4:0] pinRaw;
   logic [4:0] pinMeta_r;
   logic [4:0] pinSync_r;
   logic shutS;
   logic faultS;
   logic rxS;
   logic sclS;
   logic sdaS;
   logic sclPrev_r;
   logic sdaPrev_r;
   logic shutPrev_r;
   logic frameEdge_r;
   logic linkRst_n;
   logic [INIT_W-1:0] initCnt_r;
   logic initDone_r;
   logic initEnd;
   logic [RST_W-1:0] shutCnt_r;
   logic shutLongEnough;
   logic resetGranted;
   logic faultSet;
   logic faultLatched_r;
   logic faultNxt;
   logic laserEnable_r;
   logic laserEnNxt;
   logic faultOe_r;
   logic [LOS_W-1:0] losCnt_r;
   logic lossFlag_r;
   logic lossDiffers;
   logic lossFlip;
   logic [4:0] statusWord;

   assign pinRaw = {idLinkDataIn, idLinkClock, rxPowerSense,
                    laserFaultSense, laserShutoff};
   assign shutS = pinSync_r[PIN_SHUT];
   assign faultS = pinSync_r[PIN_FAULT];
   assign rxS = pinSync_r[PIN_RX];
   assign sclS = pinSync_r[PIN_SCL];
   assign sdaS = pinSync_r[PIN_SDA];

   // Shut-off is reset high so the laser stays dark until the pin is seen.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pinMeta_r <= PIN_RST;
         pinSync_r <= PIN_RST;
      end
      else
      begin
         pinMeta_r <= pinRaw;
         pinSync_r <= pinMeta_r;
      end
   end

   assign initEnd = initCnt_r == INIT_W'(INIT_CYCLES - 1);

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         initCnt_r <= '0;
         initDone_r <= 1'b0;
      end
      else if (!initDone_r)
      begin
         initCnt_r <= initCnt_r + INIT_W'(1);
         initDone_r <= initEnd; // [R3]
      end
   end

   // A fault clears only after shut-off was held long enough, then released.
   assign shutLongEnough = shutCnt_r >= RST_W'(RESET_MIN_CYC);
   assign resetGranted = shutPrev_r & ~shutS & shutLongEnough; // [R4]
   assign faultSet = initDone_r & faultS & laserEnable_r;
   // Set wins over clear; initialisation leaves the flag cleared.
   assign faultNxt = initDone_r &
                     (faultSet | (faultLatched_r & ~resetGranted)); // [R8]
   assign laserEnNxt = initDone_r & ~shutS & ~faultLatched_r; // [R9]

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         shutPrev_r <= 1'b1;
         shutCnt_r <= '0;
      end
      else
      begin
         shutPrev_r <= shutS;
         if (!shutS)
            shutCnt_r <= '0;
         else if (!shutLongEnough)
            shutCnt_r <= shutCnt_r + RST_W'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         faultLatched_r <= 1'b0;
         laserEnable_r <= 1'b0;
         faultOe_r <= 1'b0;
      end
      else
      begin
         faultLatched_r <= faultNxt;
         laserEnable_r <= laserEnNxt; // [R1] [R2]
         faultOe_r <= initDone_r & ~faultNxt; // [R3] [R8]
      end
   end

   // The filter rejects glitches; its span stays well inside the limit.
   assign lossDiffers = lossFlag_r == rxS;
   assign lossFlip = lossDiffers & (losCnt_r == LOS_W'(LOS_FILT_CYC - 1));

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         losCnt_r <= '0;
         lossFlag_r <= 1'b1;
      end
      else
      begin
         losCnt_r <= (lossDiffers & ~lossFlip) ?
                     losCnt_r + LOS_W'(1) : '0;
         if (lossFlip)
            lossFlag_r <= ~lossFlag_r; // [R5] [R6] [R12]
      end
   end

   assign laserEnable = laserEnable_r;
   assign initDone = initDone_r;
   assign txFaultOut = 1'b0;
   assign txFaultOe = faultOe_r;
   assign rxPowerLostOut = 1'b0;
   assign rxPowerLostOe = ~lossFlag_r;
   assign presenceTieOut = 1'b0; // [R10]
   assign presenceTieOe = 1'b1; // [R10]

   // Start and stop are seen on the oversampled lines. The registered pulse
   // resets the link logic asynchronously; it ends microseconds before the
   // next link clock edge, so its release is safe without a synchroniser.
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
         frameEdge_r <= 1'b0;
      end
      else
      begin
         sclPrev_r <= sclS;
         sdaPrev_r <= sdaS;
         frameEdge_r <= sclS & sclPrev_r & (sdaS ^ sdaPrev_r); // [R11]
      end
   end

   assign linkRst_n = reset_n & ~frameEdge_r;
   assign statusWord = {shutS, lossFlag_r, faultLatched_r,
                        laserEnable_r, initDone_r};

   // Link domain: data is sampled on the rising clock edge, where the
   // link protocol guarantees it is stable.
   omcs_link_t linkState_r;
   omcs_link_t linkNxt;
   logic [2:0] bitCnt_r;
   logic [7:0] shift_r;
   logic [7:0] txByte_r;
   logic [4:0] stMeta_r;
   logic [4:0] stSync_r;
   logic dataOe_r;
   logic byteEnd;
   logic addrHit;
   logic loadTx;
   logic counting;
   logic txBit;

   assign byteEnd = bitCnt_r == 3'h7;
   assign addrHit = shift_r[6:0] == ID_ADDR;
   assign loadTx = (linkState_r == L_AACK) | (linkState_r == L_MACK);
   assign counting = (linkState_r == L_ADDR) | (linkState_r == L_READ);
   assign txBit = txByte_r[3'h7 - bitCnt_r];

   always_comb
   begin
      case (linkState_r)
         L_ADDR: linkNxt = !byteEnd ? L_ADDR :
                           (addrHit & idLinkDataIn) ? L_AACK : L_IGNR;
         L_AACK: linkNxt = L_READ;
         L_READ: linkNxt = byteEnd ? L_MACK : L_READ;
         L_MACK: linkNxt = idLinkDataIn ? L_IGNR : L_READ;
         L_IGNR: linkNxt = L_IGNR;
         default: linkNxt = L_IGNR;
      endcase
   end

   // Status levels are each caught by two link flops; they settle during
   // the address byte, long before the first data bit.
   always_ff @(posedge idLinkClock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stMeta_r <= '0;
         stSync_r <= '0;
      end
      else
      begin
         stMeta_r <= statusWord;
         stSync_r <= stMeta_r;
      end
   end

   always_ff @(posedge idLinkClock or negedge linkRst_n)
   begin
      if (!linkRst_n)
      begin
         linkState_r <= L_ADDR;
         bitCnt_r <= '0;
         shift_r <= '0;
         txByte_r <= '0;
      end
      else
      begin
         linkState_r <= linkNxt; // [R11]
         bitCnt_r <= counting ? bitCnt_r + 3'h1 : '0;
         shift_r <= {shift_r[6:0], idLinkDataIn};
         if (loadTx)
            txByte_r <= {3'h0, stSync_r};
      end
   end

   // Data changes only while the link clock is low.
   always_ff @(negedge idLinkClock or negedge linkRst_n)
   begin
      if (!linkRst_n)
         dataOe_r <= 1'b0;
      else
         dataOe_r <= (linkState_r == L_AACK) |
                     ((linkState_r == L_READ) & ~txBit); // [R11]
   end

   assign idLinkDataOut = 1'b0;
   assign idLinkDataOe = dataOe_r;

   // Helper counters for the timing checks.
   localparam int LOS_LIM = LOS_MAX_CYC;
   logic [LOS_W-1:0] losLag_r;
   logic [ON_W-1:0] onWait_r;

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         losLag_r <= '0;
         onWait_r <= '0;
      end
      else
      begin
         losLag_r <= lossDiffers ? losLag_r + LOS_W'(1) : '0;
         onWait_r <= (laserEnNxt & ~laserEnable_r) ?
                     onWait_r + ON_W'(1) : '0;
      end
   end

   property p_offFast;
      @(posedge clk_sys) disable iff (!reset_n)
      $rose(shutS) |=> !laserEnable ##1 !laserEnable;
   endproperty
   a_offFast: assert property (p_offFast) // [R1]
      else $error("Laser still on after shut-off.");

   property p_onTime;
      @(posedge clk_sys) disable iff (!reset_n)
      onWait_r < ON_W'(ON_MAX_CYCLES);
   endproperty
   a_onTime: assert property (p_onTime) // [R2]
      else $error("Laser turn-on too slow.");

   property p_initClear;
      @(posedge clk_sys) disable iff (!reset_n)
      $rose(initDone_r) |-> !faultLatched_r ##1 (txFaultOe | faultLatched_r);
   endproperty
   a_initClear: assert property (p_initClear) // [R3]
      else $error("Fault flag not cleared at end of init.");

   property p_losAssert;
      @(posedge clk_sys) disable iff (!reset_n)
      (!rxS && !lossFlag_r) |-> losLag_r < LOS_W'(LOS_LIM);
   endproperty
   a_losAssert: assert property (p_losAssert) // [R6]
      else $error("Loss flag rise too slow.");

   property p_losDeassert;
      @(posedge clk_sys) disable iff (!reset_n)
      (rxS && lossFlag_r) |-> losLag_r < LOS_W'(LOS_LIM);
   endproperty
   a_losDeassert: assert property (p_losDeassert) // [R5]
      else $error("Loss flag fall too slow.");

   property p_lossPin;
      @(posedge clk_sys) disable iff (!reset_n)
      $changed(lossFlag_r) |-> $past(lossDiffers) && (lossFlag_r != rxS);
   endproperty
   a_lossPin: assert property (p_lossPin) // [R12]
      else $error("Loss flag changed without cause.");

   property p_faultPin;
      @(posedge clk_sys) disable iff (!reset_n)
      $past(initDone_r) |-> (txFaultOe == !faultLatched_r);
   endproperty
   a_faultPin: assert property (p_faultPin) // [R8]
      else $error("Fault pin disagrees with fault state.");

   property p_txGate;
      @(posedge clk_sys) disable iff (!reset_n)
      laserEnable |-> $past(!shutS) && $past(initDone_r);
   endproperty
   a_txGate: assert property (p_txGate) // [R9]
      else $error("Laser on while shut-off high or in init.");

   property p_presence;
      @(posedge clk_sys) disable iff (!reset_n)
      presenceTieOe && !presenceTieOut;
   endproperty
   a_presence: assert property (p_presence) // [R10]
      else $error("Presence line not held low.");

   property p_idDrive;
      @(negedge idLinkClock) disable iff (!linkRst_n)
      idLinkDataOe |-> $past(linkState_r) inside {L_AACK, L_READ};
   endproperty
   a_idDrive: assert property (p_idDrive) // [R11]
      else $error("ID data driven outside ack or read.");

   c_laserOn: cover property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(laserEnable));
   c_faultClr: cover property (@(posedge clk_sys) disable iff (!reset_n)
      resetGranted && faultLatched_r);
   c_lossSet: cover property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(lossFlag_r));
   c_idAck: cover property (@(negedge idLinkClock) disable iff (!linkRst_n)
      $past(linkState_r) == L_AACK && idLinkDataOe);
endmodule // omcs_ctrl

// *** core/omcs_pkg.sv ***
// Constants and types for the optical module control and status block.
// Behaviour
// [R1] Laser off within 10 us of shut-off.
// [R2] Laser back on within 1 ms of release.
// [R3] Initialisation, fault clear, within 300 ms.
// [R4] Host holds shut-off 10 us to clear fault.
// [R5] Loss flag drops within 80 us of light.
// [R6] Loss flag rises within 80 us of dark.
// [R7] Host keeps ID link clock at 100 kHz.
// [R8] Fault flag high on fault, else low.
// [R9] Laser enabled only while shut-off input is low.
// [R10] Presence line permanently driven low.
// [R11] ID link clock and data form serial link.
// [R12] Loss flag high below sensitivity, else low.
// [R13] Host synchronises fault and loss flags first.
package omcs_pkg;
   localparam int CLK_MHZ = 40;
   localparam int T_OFF_US = 10;
   localparam int OFF_MAX_CYC = T_OFF_US * CLK_MHZ;
   localparam int T_ON_MS = 1;
   localparam int ON_MAX_CYC = T_ON_MS * 1000 * CLK_MHZ;
   localparam int T_INIT_MS = 300;
   localparam int INIT_CYC = T_INIT_MS * 1000 * CLK_MHZ;
   localparam int T_RESET_US = 10;
   localparam int RESET_MIN_CYC = T_RESET_US * CLK_MHZ;
   localparam int T_LOS_US = 80;
   localparam int LOS_MAX_CYC = T_LOS_US * CLK_MHZ;
   localparam int LOS_FILT_US = 40;
   localparam int LOS_FILT_CYC = LOS_FILT_US * CLK_MHZ;
   localparam int ID_CLK_KHZ = 100;
   localparam int INIT_W = 24;
   localparam int RST_W = 9;
   localparam int LOS_W = 12;
   localparam int ON_W = 17;
   // Pin vector positions and reset levels (inputs idle high except fault and light).
   localparam int PIN_SHUT = 0;
   localparam int PIN_FAULT = 1;
   localparam int PIN_RX = 2;
   localparam int PIN_SCL = 3;
   localparam int PIN_SDA = 4;
   localparam logic [4:0] PIN_RST = 5'h19;
   // Status byte returned over the ID link.
   localparam int ST_INIT = 0;
   localparam int ST_LASER = 1;
   localparam int ST_FAULT = 2;
   localparam int ST_LOSS = 3;
   localparam int ST_SHUT = 4;
   // Arbitrary default ID link address.
   localparam logic [6:0] ID_ADDR_DEF = 7'h50;
   typedef enum logic [2:0] {
      L_ADDR = 3'h0,
      L_AACK = 3'h1,
      L_READ = 3'h3,
      L_MACK = 3'h2,
      L_IGNR = 3'h6
   } omcs_link_t;
endpackage

// *** verification/omcs_host_model.sv ***
// Host side model: identification link master and flag synchronisers.
`timescale 1ns/1ps
module omcs_host_model (
   input wire logic clk_sys,
   input wire logic linkClk,
   input wire logic dataOe,
   input wire logic faultOe,
   input wire logic lossOe,
   output logic idLinkClock,
   output logic idLinkData,
   output logic faultSync,
   output logic lossSync
);
   // One ID clock period is four steps of PH ticks of 64 ns, which keeps
   // the link at or below its rate limit.
   localparam int PH = (1000000 / omcs_pkg::ID_CLK_KHZ + 255) / 256;
   logic hostLow = 1'b0;
   logic [1:0] faultQ = 2'h3;
   logic [1:0] lossQ = 2'h3;
   // Both lines have pull-ups, so a released line reads high.
   assign idLinkData = !(hostLow || dataOe);
   assign faultSync = faultQ[1];
   assign lossSync = lossQ[1];
   initial idLinkClock = 1'b1;
   // The flags move with no relation to this clock, hence two flops.
   always @(posedge clk_sys)
   begin
      faultQ <= {faultQ[0], !faultOe};
      lossQ <= {lossQ[0], !lossOe};
   end
   task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--)
      begin
         repeat (PH) @(posedge linkClk);
         idLinkClock = 1'b0;
         repeat (PH) @(posedge linkClk);
         hostLow = !tx[i];
         repeat (PH) @(posedge linkClk);
         idLinkClock = 1'b1;
         repeat (PH) @(posedge linkClk);
         rx[i] = idLinkData;
      end
   endtask
   task automatic readStatus(input logic [6:0] addr, output logic ack,
      output logic [7:0] b);
      logic [8:0] r;
      @(posedge linkClk) hostLow = 1'b1;
      repeat (PH) @(posedge linkClk);
      bits({addr, 2'b11}, r);
      ack = !r[0];
      // Only one byte is wanted, so the host answers no-acknowledge.
      bits(9'h1FF, r);
      b = r[8:1];
      repeat (PH) @(posedge linkClk);
      idLinkClock = 1'b0;
      repeat (PH) @(posedge linkClk);
      hostLow = 1'b1;
      repeat (PH) @(posedge linkClk);
      idLinkClock = 1'b1;
      repeat (PH) @(posedge linkClk);
      hostLow = 1'b0;
      repeat (PH) @(posedge linkClk);
   endtask
endmodule // omcs_host_model

// *** verification/optical_module_control_status_test.sv ***
// Self-checking bench for the optical module control and status block.
`timescale 1ns/1ps
module optical_module_control_status_test;
   import omcs_pkg::*;
   localparam int INIT_SIM = 64;
   logic clk_sys, reset_n, linkClk, laserShutoff, laserFaultSense;
   logic rxPowerSense, idLinkClock, idLinkData, idLinkDataOut, idLinkDataOe;
   logic laserEnable, txFaultOut, txFaultOe, rxPowerLostOut, rxPowerLostOe;
   logic presenceTieOut, presenceTieOe, initDone, faultSync, lossSync, ack;
   logic [7:0] b;
   int numErrors = 0;
   int checks = 0;
   int seed, n, mShut, mFault, mLight, mInit;
   wire logic [3:0] obs = {initDone, lossSync, faultSync, laserEnable};
   wire logic presenceWire = presenceTieOe ? presenceTieOut : 1'b1;
   omcs_ctrl #(.INIT_CYCLES(INIT_SIM)) u_omcs_ctrl (.clk_sys(clk_sys),
      .reset_n(reset_n), .laserShutoff(laserShutoff),
      .laserFaultSense(laserFaultSense), .rxPowerSense(rxPowerSense),
      .idLinkClock(idLinkClock), .idLinkDataIn(idLinkData),
      .idLinkDataOut(idLinkDataOut), .idLinkDataOe(idLinkDataOe),
      .laserEnable(laserEnable), .txFaultOut(txFaultOut),
      .txFaultOe(txFaultOe), .rxPowerLostOut(rxPowerLostOut),
      .rxPowerLostOe(rxPowerLostOe), .presenceTieOut(presenceTieOut),
      .presenceTieOe(presenceTieOe), .initDone(initDone));
   omcs_host_model u_omcs_host_model (.clk_sys(clk_sys), .linkClk(linkClk),
      .dataOe(idLinkDataOe), .faultOe(txFaultOe), .lossOe(rxPowerLostOe),
      .idLinkClock(idLinkClock), .idLinkData(idLinkData),
      .faultSync(faultSync), .lossSync(lossSync));
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = !clk_sys;
   end
   initial
   begin
      linkClk = 1'b0;
      #7.3;
      forever #32 linkClk = !linkClk;
   end
   function automatic logic [7:0] expStatus();
      logic f;
      f = mFault != 0 || mInit == 0;
      return {3'h0, mShut != 0, mLight == 0, f,
         mInit != 0 && mShut == 0 && mFault == 0, mInit != 0};
   endfunction
   task automatic results();
      $display("checks %0d errors %0d", checks, numErrors);
      if (numErrors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic checkBit(input string what, input logic e, input logic s);
      checks++;
      numErrors += (s !== e);
      if (s !== e) $display("mismatch %s expected %b seen %b", what, e, s);
   endtask
   task automatic checkByte(input string what, input logic [7:0] e,
      input logic [7:0] s);
      checks++;
      numErrors += (s !== e);
      if (s !== e) $display("mismatch %s expected %h seen %h", what, e, s);
   endtask
   // Latency check: the bound ends the wait, so no wait can hang.
   task automatic waitObs(input int i, input logic v, input int bound);
      n = 0;
      while (obs[i] !== v && n <= bound)
      begin
         @(negedge clk_sys);
         n++;
      end
      checks++;
      if (n > bound)
      begin
         $display("mismatch wait%0d expected %b seen %b", i, v, obs[i]);
         numErrors++;
         results();
      end
   endtask
   task automatic readCheck(input logic [6:0] a, input logic eAck);
      u_omcs_host_model.readStatus(a, ack, b);
      checkBit("ack", eAck, ack);
      if (eAck) checkByte("status", expStatus(), b);
   endtask
   task automatic drive(input int s, input int f, input int l);
      @(negedge clk_sys);
      laserShutoff = s[0];
      laserFaultSense = f[0];
      rxPowerSense = l[0];
      mShut = s;
      mLight = l;
   endtask
   initial
   begin
      seed = 32'h89E0;
      {mFault, mInit} = 0;
      reset_n = 1'b0;
      drive(1, 0, 0);
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      checkBit("laser", 1'b0, laserEnable);
      checkBit("fault", 1'b1, faultSync);
      checkBit("loss", 1'b1, lossSync);
      checkBit("presence", 1'b0, presenceWire);
      checkBit("fault drive", 1'b0, txFaultOut);
      checkBit("loss drive", 1'b0, rxPowerLostOut);
      checkBit("id drive", 1'b0, idLinkDataOut);
      reset_n = 1'b1;
      waitObs(3, 1'b1, INIT_SIM + 2);
      mInit = 1;
      waitObs(1, 1'b0, 4);
      repeat (8) @(negedge clk_sys);
      checkBit("laser", 1'b0, laserEnable);
      readCheck(ID_ADDR_DEF, 1'b1);
      readCheck(ID_ADDR_DEF ^ 7'(($random(seed) & 32'h3F) | 1), 1'b0);
      drive(1, 0, 1);
      waitObs(2, 1'b0, LOS_MAX_CYC);
      drive(0, 0, 1);
      waitObs(0, 1'b1, ON_MAX_CYC);
      for (int k = 0; k < 2; k++) readCheck(ID_ADDR_DEF, 1'b1);
      drive(0, 0, 0);
      repeat (100 + ($random(seed) & 32'h3FF)) @(negedge clk_sys);
      drive(0, 0, 1);
      repeat (100) @(negedge clk_sys);
      checkBit("loss glitch", 1'b0, lossSync);
      drive(0, 0, 0);
      waitObs(2, 1'b1, LOS_MAX_CYC);
      drive(0, 0, 1);
      waitObs(2, 1'b0, LOS_MAX_CYC);
      drive(1, 0, 1);
      waitObs(0, 1'b0, OFF_MAX_CYC);
      drive(0, 0, 1);
      waitObs(0, 1'b1, ON_MAX_CYC);
      drive(0, 1, 1);
      mFault = 1;
      waitObs(1, 1'b1, 8);
      waitObs(0, 1'b0, 8);
      drive(0, 0, 1);
      readCheck(ID_ADDR_DEF, 1'b1);
      // A pulse shorter than the clearing time must leave the fault set.
      drive(1, 0, 1);
      repeat (20 + ($random(seed) & 32'hFF)) @(negedge clk_sys);
      drive(0, 0, 1);
      repeat (50) @(negedge clk_sys);
      checkBit("fault kept", 1'b1, faultSync);
      checkBit("laser kept", 1'b0, laserEnable);
      drive(1, 0, 1);
      repeat (RESET_MIN_CYC + 10) @(negedge clk_sys);
      drive(0, 0, 1);
      mFault = 0;
      waitObs(1, 1'b0, 10);
      waitObs(0, 1'b1, 10);
      readCheck(ID_ADDR_DEF, 1'b1);
      // Reset spans clock edges so the checks see it, not a runt pulse.
      @(negedge clk_sys);
      reset_n = 1'b0;
      mInit = 0;
      repeat (2) @(negedge clk_sys);
      checkBit("laser reset", 1'b0, laserEnable);
      checkBit("init reset", 1'b0, initDone);
      reset_n = 1'b1;
      waitObs(3, 1'b1, INIT_SIM + 2);
      mInit = 1;
      waitObs(1, 1'b0, 4);
      waitObs(0, 1'b1, 10);
      results();
   end
   initial
   begin
      #2500000;
      $display("mismatch run expected end seen timeout");
      numErrors++;
      results();
   end
endmodule // optical_module_control_status_test
